// File: src/tcc_pkg.sv
`default_nettype none
package tcc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PRE_W = 12;

  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_MODE0 = 4'h0;
  localparam logic [3:0] ADDR_MODE1 = 4'h1;
  localparam logic [3:0] ADDR_MATCH0 = 4'h2;
  localparam logic [3:0] ADDR_MATCH1 = 4'h3;
  localparam logic [3:0] ADDR_PSEL0 = 4'h4;
  localparam logic [3:0] ADDR_PSEL1 = 4'h5;
  localparam logic [3:0] ADDR_EDGE = 4'h6;
  localparam logic [3:0] ADDR_FLAGS = 4'h7;
  localparam logic [3:0] ADDR_COUNT0 = 4'h8;
  localparam logic [3:0] ADDR_COUNT1 = 4'h9;

  // Field positions.
  localparam int M0_CLK_LSB = 0;
  localparam int M1_CLK_LSB = 0;
  localparam int MODE_RUN_BIT = 3;
  localparam int MODE_CAP_BIT = 4;
  localparam int M1_CHAIN_BIT = 5;
  localparam int M1_PWM_BIT = 6;
  localparam int PSEL0_TIMER0_CAPTURE_SELECT_BIT = 0;
  localparam int PSEL0_TIMER1_CAPTURE_SELECT_BIT = 1;
  localparam int PSEL0_EVENT_BIT = 4;
  localparam int PSEL1_CMP_BIT = 0;
  localparam int FLAG_T0_BIT = 0;
  localparam int FLAG_T1_BIT = 1;
  localparam int FLAG_X0_BIT = 2;
  localparam int FLAG_X1_BIT = 3;

  // Clock select codes.
  localparam logic [2:0] T0_SEL_EVENT = 3'h7;
  localparam logic [1:0] T1_SEL_CHAIN = 2'h3;

  // Edge select codes, two bits per capture pin.
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
endpackage : tcc_pkg
`default_nettype wire

// File: src/tcc_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
module tcc_prescaler
  import tcc_pkg::*;
(
  // Clock and reset.
  input wire logic clock_in,
  input wire logic rstn_in,
  // Taps: bit k pulses once every 2**(k+1) cycles.
  output logic [PRE_W-1:0] tap_out
);
  logic [PRE_W-1:0] count;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  genvar k;
  generate
    for (k = 0; k < PRE_W; k++) begin : g_tap
      assign tap_out[k] = &count[k:0];
    end
  endgenerate
endmodule // tcc_prescaler
`default_nettype wire

// File: src/tcc_edge_detect.sv
`timescale 1ns/100ps
`default_nettype none
module tcc_edge_detect
  import tcc_pkg::*;
(
  // Clock and reset.
  input wire logic clock_in,
  input wire logic rstn_in,
  // Pin and edge choice.
  input wire logic pin_in,
  input wire logic [1:0] edge_sel_in,
  // One-cycle pulse on a qualifying edge.
  output logic hit_out
);
  logic last;
  wire rise = pin_in & ~last;
  wire fall = ~pin_in & last;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last <= 1'b0;
    end else begin
      last <= pin_in;
    end
  end

  assign hit_out = (edge_sel_in == EDGE_RISE) ? rise :
                   (edge_sel_in == EDGE_FALL) ? fall :
                   (edge_sel_in == EDGE_BOTH) ? (rise | fall) : 1'b0;
endmodule // tcc_edge_detect
`default_nettype wire

// File: src/tcc_timer.sv
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
//Contract
// - Timer 0 divides by 2..2048 selectable.
// - Timer 1 divides by 1, 2 or 8.
// - Count to match, flag, clear, continue.
// - Event mode counts routed event rising edges.
// - Only timer 0 counts external events.
// - Reset clears both match registers.
// - Interval is two times ratio times N+1.
// - Chained counter matches sixteen bits, timer0 flag.
// - Compare pin gives equal-duty square wave.
// - Compare frequency follows match interval formula.
// - Capture mode still counts and flags matches.
// - Capture edge copies counter then clears it.
// - Edge falling, rising or both; raises flag.
// - Capture mode reads capture at match address.
module tcc_timer
  import tcc_pkg::*;
(
  // Clock and reset.
  input wire logic clock_in,
  input wire logic rstn_in,
  // Register port.
  input wire logic [tcc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [tcc_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [tcc_pkg::DATA_W-1:0] rdata_out,
  // Pins.
  input wire logic event_count_pin_in,
  input wire logic [1:0] capture_input_pin_in,
  output logic compare_out_pin_out,
  output logic compare_out_enable_out,
  // Interrupt flags: timer 0, timer 1, capture pin 0, capture pin 1.
  output logic [3:0] irq_flag_out
);
  import tcc_pkg::*;

  logic [7:0] timer0_mode_reg;
  logic [7:0] timer1_mode_reg;
  logic [7:0] timer0_match_reg;
  logic [7:0] timer1_match_reg;
  logic [7:0] capture_value_reg [0:1];
  logic [7:0] port_select_reg0;
  logic [7:0] port_select_reg1;
  logic [7:0] irq_edge_select_reg;
  logic [7:0] count [0:1];
  logic last_event;

  logic [PRE_W-1:0] tap;
  logic [1:0] cap_hit;

  // Tap index for a timer 0 clock code.
  function automatic logic [3:0] t0_tap(input logic [2:0] sel);
    case (sel)
      3'h0: t0_tap = 4'h1;
      3'h1: t0_tap = 4'h2;
      3'h2: t0_tap = 4'h3;
      3'h3: t0_tap = 4'h5;
      3'h4: t0_tap = 4'h7;
      3'h5: t0_tap = 4'h9;
      default: t0_tap = 4'hb;
    endcase
  endfunction

  // Tap index for a timer 1 clock code.
  function automatic logic [3:0] t1_tap(input logic [1:0] sel);
    case (sel)
      2'h0: t1_tap = 4'h0;
      2'h1: t1_tap = 4'h1;
      default: t1_tap = 4'h3;
    endcase
  endfunction

  tcc_prescaler u_prescaler (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .tap_out(tap)
  );

  // Capture edge detectors, one per capture pin.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_cap
      tcc_edge_detect u_edge (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .pin_in(capture_input_pin_in[g]),
        .edge_sel_in(irq_edge_select_reg[2*g+1:2*g]),
        .hit_out(cap_hit[g])
      );
    end
  endgenerate

  // Mode decoding.
  wire [2:0] sel0 = timer0_mode_reg[M0_CLK_LSB+2:M0_CLK_LSB];
  wire [1:0] sel1 = timer1_mode_reg[M1_CLK_LSB+1:M1_CLK_LSB];
  wire run0 = timer0_mode_reg[MODE_RUN_BIT];
  wire run1 = timer1_mode_reg[MODE_RUN_BIT];
  wire cap_mode0 = timer0_mode_reg[MODE_CAP_BIT];
  wire cap_mode1 = timer1_mode_reg[MODE_CAP_BIT];
  wire pwm1 = timer1_mode_reg[M1_PWM_BIT];
  wire chain = timer1_mode_reg[M1_CHAIN_BIT] && (sel1 == T1_SEL_CHAIN);
  wire event_rise = event_count_pin_in & ~last_event
                    & port_select_reg0[PSEL0_EVENT_BIT];

  wire tick0 = run0 && ((sel0 == T0_SEL_EVENT) ? event_rise
                        : tap[t0_tap(sel0)]);
  wire tick1 = run1 && !pwm1 && (sel1 != T1_SEL_CHAIN)
               && tap[t1_tap(sel1)];

  // Capture pin qualification; routing bits gate each pin.
  wire x0_hit = cap_hit[0] && port_select_reg0[PSEL0_TIMER0_CAPTURE_SELECT_BIT];
  wire x1_hit = cap_hit[1] && port_select_reg0[PSEL0_TIMER1_CAPTURE_SELECT_BIT];
  wire chain_cap = chain && (cap_mode0 || cap_mode1);
  wire timer0_capture_select_go = (chain ? chain_cap : cap_mode0) && x0_hit;
  wire timer1_capture_select_go = !chain && cap_mode1 && x1_hit;

  wire [15:0] count16 = {count[1], count[0]};
  wire [15:0] match16 = {timer1_match_reg, timer0_match_reg};
  wire match0 = chain ? (tick0 && count16 == match16)
                      : (tick0 && count[0] == timer0_match_reg);
  wire match1 = !chain && tick1 && count[1] == timer1_match_reg;

  // Next counter values; a capture clears ahead of any tick.
  logic [7:0] next_count0;
  logic [7:0] next_count1;
  logic [15:0] inc16;
  always_comb begin
    inc16 = count16 + 16'h0001;
    next_count0 = count[0];
    next_count1 = count[1];
    if (chain) begin
      if (timer0_capture_select_go || match0) begin
        next_count0 = 8'h00;
        next_count1 = 8'h00;
      end else if (tick0) begin
        next_count0 = inc16[7:0];
        next_count1 = inc16[15:8];
      end
    end else begin
      if (timer0_capture_select_go || match0) begin
        next_count0 = 8'h00;
      end else if (tick0) begin
        next_count0 = count[0] + 8'h01;
      end
      if (timer1_capture_select_go || match1) begin
        next_count1 = 8'h00;
      end else if (tick1) begin
        next_count1 = count[1] + 8'h01;
      end
    end
  end

  // Register write decode.
  wire wr_mode0 = wr_in && addr_in == ADDR_MODE0;
  wire wr_mode1 = wr_in && addr_in == ADDR_MODE1;
  wire wr_match0 = wr_in && addr_in == ADDR_MATCH0;
  wire wr_match1 = wr_in && addr_in == ADDR_MATCH1;
  wire wr_psel0 = wr_in && addr_in == ADDR_PSEL0;
  wire wr_psel1 = wr_in && addr_in == ADDR_PSEL1;
  wire wr_edge = wr_in && addr_in == ADDR_EDGE;
  wire wr_flags = wr_in && addr_in == ADDR_FLAGS;

  // Hardware events; a set in the same cycle as a clear wins.
  wire [3:0] flag_set = {x1_hit, x0_hit, match1 && !chain,
                         match0};
  wire [3:0] flag_clr = wr_flags ? wdata_in[3:0] : 4'h0;
  wire [3:0] next_flags = flag_set | (irq_flag_out & ~flag_clr);

  // Match address reads the capture register in capture mode.
  wire [7:0] rd_match0 = (cap_mode0 || chain_cap) ? capture_value_reg[0]
                         : timer0_match_reg;
  wire [7:0] rd_match1 = (cap_mode1 || chain_cap) ? capture_value_reg[1]
                         : timer1_match_reg;
  logic [7:0] rd_mux;
  always_comb begin
    if (addr_in == ADDR_MODE0) begin
      rd_mux = timer0_mode_reg;
    end else if (addr_in == ADDR_MODE1) begin
      rd_mux = timer1_mode_reg;
    end else if (addr_in == ADDR_MATCH0) begin
      rd_mux = rd_match0;
    end else if (addr_in == ADDR_MATCH1) begin
      rd_mux = rd_match1;
    end else if (addr_in == ADDR_PSEL0) begin
      rd_mux = port_select_reg0;
    end else if (addr_in == ADDR_PSEL1) begin
      rd_mux = port_select_reg1;
    end else if (addr_in == ADDR_EDGE) begin
      rd_mux = irq_edge_select_reg;
    end else if (addr_in == ADDR_FLAGS) begin
      rd_mux = {4'h0, irq_flag_out};
    end else if (addr_in == ADDR_COUNT0) begin
      rd_mux = count[0];
    end else if (addr_in == ADDR_COUNT1) begin
      rd_mux = count[1];
    end else begin
      rd_mux = READ_UNMAPPED;
    end
  end

  // Control registers.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      timer0_mode_reg <= RESET_VALUE;
      timer1_mode_reg <= RESET_VALUE;
      port_select_reg0 <= RESET_VALUE;
      port_select_reg1 <= RESET_VALUE;
      irq_edge_select_reg <= RESET_VALUE;
    end else begin
      if (wr_mode0) timer0_mode_reg <= wdata_in;
      if (wr_mode1) timer1_mode_reg <= wdata_in;
      if (wr_psel0) port_select_reg0 <= wdata_in;
      if (wr_psel1) port_select_reg1 <= wdata_in;
      if (wr_edge) irq_edge_select_reg <= wdata_in;
    end
  end

  // Match registers.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      timer0_match_reg <= RESET_VALUE;
      timer1_match_reg <= RESET_VALUE;
    end else begin
      if (wr_match0) timer0_match_reg <= wdata_in;
      if (wr_match1) timer1_match_reg <= wdata_in;
    end
  end

  // Counters and capture registers.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count[0] <= RESET_VALUE;
      count[1] <= RESET_VALUE;
      capture_value_reg[0] <= RESET_VALUE;
      capture_value_reg[1] <= RESET_VALUE;
      last_event <= 1'b0;
    end else begin
      count[0] <= next_count0;
      count[1] <= next_count1;
      last_event <= event_count_pin_in;
      if (timer0_capture_select_go) begin
        capture_value_reg[0] <= count[0];
        if (chain) capture_value_reg[1] <= count[1];
      end
      if (timer1_capture_select_go) capture_value_reg[1] <= count[1];
    end
  end

  // Flags, read data and compare pin.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_flag_out <= 4'h0;
      rdata_out <= RESET_VALUE;
      compare_out_pin_out <= 1'b0;
      compare_out_enable_out <= 1'b0;
    end else begin
      irq_flag_out <= next_flags;
      rdata_out <= rd_in ? rd_mux : RESET_VALUE;
      compare_out_enable_out <= port_select_reg1[PSEL1_CMP_BIT];
      if (match0) begin
        compare_out_pin_out <= ~compare_out_pin_out;
      end
    end
  end
endmodule // tcc_timer
`default_nettype wire

// File: sim/tcc_timer_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_monitor
  import tcc_pkg::*;
(
  // Clock and reset.
  input wire logic clock_in,
  input wire logic rstn_in,
  // Register port.
  input wire logic [tcc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [tcc_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [tcc_pkg::DATA_W-1:0] rdata_out,
  // Pins and flags.
  input wire logic event_count_pin_in,
  input wire logic [1:0] capture_input_pin_in,
  input wire logic compare_out_pin_out,
  input wire logic compare_out_enable_out,
  input wire logic [3:0] irq_flag_out
);
  logic chain;
  wire logic wr_flags = wr_in && addr_in == ADDR_FLAGS;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      chain <= 1'b0;
    end else if (wr_in && addr_in == ADDR_MODE1) begin
      chain <= wdata_in[M1_CHAIN_BIT] && wdata_in[1:0] == T1_SEL_CHAIN;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  sequence s_flag_rd;
    rd_in && addr_in == ADDR_FLAGS;
  endsequence
  property p_rst;
    !$past(rstn_in) |-> irq_flag_out == 4'h0 && !compare_out_pin_out;
  endproperty
  // The enable pin follows the routing register one cycle after the write.
  property p_en;
    wr_in && addr_in == ADDR_PSEL1 |=> ##1
      compare_out_enable_out == $past(wdata_in[PSEL1_CMP_BIT], 2);
  endproperty
  property p_flag_rd;
    s_flag_rd |=> rdata_out == {4'h0, $past(irq_flag_out)};
  endproperty
  property p_sticky;
    1'b1 |-> ($past(irq_flag_out) & ~irq_flag_out &
      ~($past(wr_flags) ? $past(wdata_in[3:0]) : 4'h0)) == 4'h0;
  endproperty
  property p_chain;
    chain && $past(chain, 2) |-> !$rose(irq_flag_out[FLAG_T1_BIT]);
  endproperty
  property p_tog_flag;
    $changed(compare_out_pin_out) |-> ##[0:1] irq_flag_out[FLAG_T0_BIT];
  endproperty
  property p_tog_gap;
    $changed(compare_out_pin_out) |=> $stable(compare_out_pin_out);
  endproperty
  property p_rd_idle;
    !rd_in |=> rdata_out == 8'h00;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not clear after reset");
  a_en: assert property (p_en)
    else $error("compare enable wrong");
  a_flag_rd: assert property (p_flag_rd)
    else $error("flag read wrong");
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without clear");
  a_chain: assert property (p_chain)
    else $error("timer 1 flag in chained mode");
  a_tog_flag: assert property (p_tog_flag)
    else $error("toggle without match flag");
  a_tog_gap: assert property (p_tog_gap)
    else $error("compare toggled twice in a row");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
endmodule // tcc_timer_monitor
bind tcc_timer tcc_timer_monitor u_mon (
  .clock_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
  .event_count_pin_in, .capture_input_pin_in, .compare_out_pin_out,
  .compare_out_enable_out, .irq_flag_out
);
`default_nettype wire

// File: sim/tcc_pins_model.sv
`timescale 1ns/100ps
`default_nettype none
module tcc_pins_model (
  // Clock.
  input wire logic clock_in,
  // Pins.
  input wire logic cmp_in,
  output logic event_out,
  output logic [1:0] cap_out
);
  int toggles = 0;
  int interval = 0;
  int cyc = 0;
  int last = 0;
  logic prev = 1'b0;
  initial begin
    event_out = 1'b0;
    cap_out = 2'b00;
  end
  // Rising edges come no closer than two cycles apart.
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clock_in) event_out <= 1'b1;
      @(posedge clock_in) event_out <= 1'b0;
    end
    repeat (2) @(posedge clock_in);
  endtask
  task automatic cap(input int i, input logic v);
    @(posedge clock_in) cap_out[i] <= v;
    repeat (4) @(posedge clock_in);
  endtask
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    prev <= cmp_in;
    if (cmp_in !== prev) begin
      toggles <= toggles + 1;
      interval <= cyc - last;
      last <= cyc;
    end
  end
endmodule // tcc_pins_model
`default_nettype wire

// File: sim/tb_tcc_timer.sv
`timescale 1ns/100ps
`default_nettype none
module tb_tcc_timer;
  import tcc_pkg::*;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] rdata_out;
  logic ev, cmp, cmp_en;
  logic [1:0] cap;
  logic [3:0] irq;
  int mismatches = 0;
  int compares = 0;
  int ratio [7] = '{2, 4, 8, 32, 128, 512, 2048};
  int r1 [3] = '{1, 2, 8};
  always #2 clock_in = ~clock_in;
  tcc_timer DUT (.clock_in(clock_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .event_count_pin_in(ev), .capture_input_pin_in(cap),
    .compare_out_pin_out(cmp), .compare_out_enable_out(cmp_en),
    .irq_flag_out(irq));
  tcc_pins_model m (.clock_in(clock_in), .cmp_in(cmp), .event_out(ev),
    .cap_out(cap));
  task automatic print_verdict(input bit late);
    if (late) mismatches++;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 check(rdata_out, exp);
  endtask
  task automatic wait_tog();
    int t0;
    t0 = m.toggles;
    for (int i = 0; i < 20000 && m.toggles == t0; i++) @(posedge clock_in);
    if (m.toggles == t0) print_verdict(1'b1);
  endtask
  // Waits for the timer 1 flag, notes the cycle and clears the flag.
  task automatic wait_t1(output int c);
    @(posedge clock_in);
    for (int i = 0; i < 20000 && !irq[FLAG_T1_BIT]; i++) @(posedge clock_in);
    if (irq[FLAG_T1_BIT] !== 1'b1) print_verdict(1'b1);
    c = m.cyc;
    wr(ADDR_FLAGS, 8'h02);
  endtask
  initial begin
    int t;
    int c0;
    int c1;
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    rd(ADDR_MATCH0, 8'h00);
    rd(ADDR_MATCH1, 8'h00);
    rd(4'hf, READ_UNMAPPED);
    wr(ADDR_PSEL1, 8'h01);
    @(posedge clock_in);
    #1 check(cmp_en, 1'b1);
    wr(ADDR_MATCH0, 8'h01);
    for (int s = 0; s < 7; s++) begin
      wr(ADDR_MODE0, 8'h08 | 8'(s));
      wait_tog();
      wait_tog();
      check(16'(m.interval), 16'(4 * ratio[s]));
    end
    check(irq[FLAG_T0_BIT], 1'b1);
    wr(ADDR_MODE0, 8'h00);
    wr(ADDR_FLAGS, 8'h0f);
    rd(ADDR_FLAGS, 8'h00);
    wr(ADDR_PSEL0, 8'h11);
    wr(ADDR_MATCH0, 8'h02);
    wr(ADDR_MODE0, 8'h0f);
    m.pulse(2);
    rd(ADDR_COUNT0, 8'h02);
    t = m.toggles;
    m.pulse(1);
    check(16'(m.toggles - t), 16'h1);
    rd(ADDR_COUNT0, 8'h00);
    wr(ADDR_MATCH1, 8'h01);
    wr(ADDR_MATCH0, 8'h01);
    wr(ADDR_MODE1, 8'h2b);
    wr(ADDR_FLAGS, 8'h0f);
    t = m.toggles;
    m.pulse(257);
    rd(ADDR_COUNT1, 8'h01);
    check(16'(m.toggles - t), 16'h0);
    m.pulse(1);
    check(16'(m.toggles - t), 16'h1);
    rd(ADDR_FLAGS, 8'h01);
    wr(ADDR_MODE1, 8'h00);
    wr(ADDR_MATCH0, 8'hff);
    wr(ADDR_MODE0, 8'h1f);
    wr(ADDR_EDGE, {6'h00, EDGE_RISE});
    m.pulse(5);
    m.cap(0, 1'b1);
    rd(ADDR_MATCH0, 8'h05);
    rd(ADDR_COUNT0, 8'h00);
    for (int e = 0; e < 4; e++) begin
      wr(ADDR_EDGE, 8'(e));
      wr(ADDR_FLAGS, 8'h0f);
      m.cap(0, 1'b0);
      rd(ADDR_FLAGS, {5'h00, e[0], 2'b00});
      wr(ADDR_FLAGS, 8'h0f);
      m.cap(0, 1'b1);
      rd(ADDR_FLAGS, {5'h00, e[1], 2'b00});
    end
    // Timer 1 rates, measured between two match flags.
    wr(ADDR_MATCH1, 8'h07);
    for (int s = 0; s < 3; s++) begin
      wr(ADDR_MODE1, 8'h08 | 8'(s));
      wait_t1(c0);
      wait_t1(c1);
      check(16'(c1 - c0), 16'(16 * r1[s]));
    end
    // Timer 1 capture on pin 1, stopped counter.
    wr(ADDR_MODE1, 8'h10);
    wr(ADDR_PSEL0, 8'h13);
    wr(ADDR_EDGE, 8'h0b);
    wr(ADDR_FLAGS, 8'h0f);
    m.cap(1, 1'b1);
    rd(ADDR_FLAGS, 8'h08);
    m.cap(1, 1'b0);
    m.cap(1, 1'b1);
    rd(ADDR_MATCH1, 8'h00);
    rd(ADDR_COUNT1, 8'h00);
    // Chained 16-bit capture on pin 0.
    wr(ADDR_MATCH1, 8'hff);
    wr(ADDR_MODE1, 8'h33);
    m.cap(0, 1'b0);
    m.pulse(300);
    m.cap(0, 1'b1);
    rd(ADDR_MATCH0, 8'h2c);
    rd(ADDR_MATCH1, 8'h01);
    print_verdict(1'b0);
  end
endmodule // tb_tcc_timer
`default_nettype wire
